/* File: dcf_fifo_mailbox.sv */
// dual-clock fifo with mailboxes; port clocks sampled on aclk, control over axi4-lite
// Operation
// - transfers only on qualified port clock edges
// - port clocks independent, any phase or frequency; here both are sampled on aclk, so each must stay below half its rate
// - 2048 by 36 array, a in, b out
// - each port has 36-bit two-way bus
// - full and empty shown to each side
// - input-ready and almost-full two-flop on port a
// - output-ready and almost-empty two-flop on port b
// - almost-empty low when count at most x
// - almost-full low when vacancy at most y
// - offsets load from port a or serially
// - port b may re-read already read words
// - two 36-bit mailboxes, one per direction
// - each mailbox flags unread new mail
// - a-to-b mail flag low on write, high on read
// - 22 serial bits, y msb first, x lsb last
// - input-ready low means full, low in reset
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
module dcf_fifo_mailbox (
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic                          port_a_clock,
	input  wire logic                          port_a_select_n,
	input  wire logic                          port_a_gate,
	input  wire logic                          port_a_write,
	input  wire logic                          port_a_mbox,
	input  wire logic [dcf_pkg::DATA_W-1:0]    port_a_bus_in,
	output logic      [dcf_pkg::DATA_W-1:0]    port_a_bus_out,
	output logic                               port_a_bus_oe,
	input  wire logic                          port_b_clock,
	input  wire logic                          port_b_select_n,
	input  wire logic                          port_b_gate,
	input  wire logic                          port_b_write,
	input  wire logic                          port_b_mbox,
	input  wire logic [dcf_pkg::DATA_W-1:0]    port_b_bus_in,
	output logic      [dcf_pkg::DATA_W-1:0]    port_b_bus_out,
	output logic                               port_b_bus_oe,
	input  wire logic                          offset_serial_strobe_n,
	input  wire logic                          offset_serial_bit,
	output logic                               input_ready_flag,
	output logic                               output_ready_flag,
	output logic                               almost_full_flag_n,
	output logic                               almost_empty_flag_n,
	output logic                               inbox_to_b_flag_n,
	output logic                               inbox_to_a_flag_n,
	input  wire logic [dcf_pkg::AXI_AW-1:0]    s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [dcf_pkg::AXI_DW-1:0]    s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic      [1:0]                    s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [dcf_pkg::AXI_AW-1:0]    s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic      [dcf_pkg::AXI_DW-1:0]    s_axi_rdata,
	output logic      [1:0]                    s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready
);
	logic [dcf_pkg::DATA_W-1:0] mem [dcf_pkg::DEPTH];
	logic [dcf_pkg::DATA_W-1:0] buf_data [dcf_pkg::BUF_DEPTH];
	logic                       a_clk_q;
	logic                       b_clk_q;
	logic                       a_edge;
	logic                       b_edge;
	logic                       a_op;
	logic                       b_op;
	logic                       a_fifo_wr;
	logic                       a_mb_wr;
	logic                       a_mb_rd;
	logic                       b_fifo_rd;
	logic                       b_mb_rd;
	logic                       b_mb_wr;
	logic [dcf_pkg::PTR_W-1:0]  wr_ptr;
	logic [dcf_pkg::PTR_W-1:0]  rd_ptr;
	logic [dcf_pkg::PTR_W-1:0]  next_rd_ptr;
	logic [dcf_pkg::PTR_W-1:0]  mark_ptr;
	logic [dcf_pkg::PTR_W-1:0]  stored;
	logic [dcf_pkg::PTR_W-1:0]  held;
	logic [dcf_pkg::PTR_W-1:0]  occ;
	logic                       arr_full;
	logic                       arr_empty;
	logic                       buf_head;
	logic [1:0]                 buf_cnt;
	logic                       buf_push;
	logic                       buf_pop;
	logic                       ir_s1;
	logic                       af_s1;
	logic                       or_s1;
	logic                       ae_s1;
	logic [dcf_pkg::OFS_W-1:0]  ofs_x;
	logic [dcf_pkg::OFS_W-1:0]  ofs_y;
	logic [4:0]                 ser_cnt;
	dcf_pkg::dcf_prog_t         prog;
	logic [dcf_pkg::DATA_W-1:0] mail_ab;
	logic [dcf_pkg::DATA_W-1:0] mail_ba;
	logic                       ctrl_serial;
	logic                       ctrl_hold;
	logic                       retx;
	logic [dcf_pkg::AXI_AW-1:0] aw_q;
	logic [dcf_pkg::AXI_DW-1:0] w_q;
	logic                       wstrb0_q;
	logic                       do_write;
	logic [dcf_pkg::AXI_DW-1:0] rd_word;
	logic                       rd_hit;

	function automatic logic [dcf_pkg::PTR_W-1:0] ptr_dist(input logic [dcf_pkg::PTR_W-1:0] hi,
		input logic [dcf_pkg::PTR_W-1:0] lo);
		ptr_dist = hi - lo;
	endfunction

	// port clocks arrive synchronous to aclk, so a plain edge detect is safe
	always_ff @(posedge aclk)
	begin
		a_clk_q <= port_a_clock;
		b_clk_q <= port_b_clock;
	end

	always_comb
	begin
		a_edge      = port_a_clock & ~a_clk_q;
		b_edge      = port_b_clock & ~b_clk_q;
		a_op        = a_edge & ~port_a_select_n & port_a_gate;
		b_op        = b_edge & ~port_b_select_n & port_b_gate;
		a_fifo_wr   = a_op & port_a_write & ~port_a_mbox;
		a_mb_wr     = a_op & port_a_write & port_a_mbox;
		a_mb_rd     = a_op & ~port_a_write & port_a_mbox;
		b_mb_rd     = b_op & ~port_b_write & port_b_mbox;
		b_mb_wr     = b_op & port_b_write & port_b_mbox;
		stored      = ptr_dist(wr_ptr, rd_ptr);
		held        = ptr_dist(wr_ptr, mark_ptr);
		occ         = held + dcf_pkg::PTR_W'(buf_cnt);
		arr_full    = held == dcf_pkg::DEPTH_CNT;
		arr_empty   = stored == '0;
		// the raw array test also guards the lag of the synchronised flag
		b_fifo_rd   = b_op & ~port_b_write & ~port_b_mbox & output_ready_flag & ~arr_empty;
		buf_push    = a_fifo_wr & input_ready_flag & (prog == dcf_pkg::DCF_PROG_DONE)
			& (buf_cnt != dcf_pkg::BUF_FULL);
		buf_pop     = (buf_cnt != '0) & ~arr_full;
		next_rd_ptr = retx ? mark_ptr : (b_fifo_rd ? rd_ptr + 1'b1 : rd_ptr);
	end

	// two-entry buffer between port a and the array; it stalls while the array is full
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			buf_cnt  <= '0;
			buf_head <= 1'b0;
		end
		else
		begin
			if (buf_pop)
				buf_head <= ~buf_head;
			unique case ({buf_push, buf_pop})
				2'b10:   buf_cnt <= buf_cnt + 1'b1;
				2'b01:   buf_cnt <= buf_cnt - 1'b1;
				default: buf_cnt <= buf_cnt;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (buf_push)
			buf_data[buf_head ^ buf_cnt[0]] <= port_a_bus_in;
		if (buf_pop)
			mem[wr_ptr[dcf_pkg::ADDR_W-1:0]] <= buf_data[buf_head];
	end

	// the mark follows the read side unless held, so retransmit has a floor to return to
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wr_ptr   <= '0;
			rd_ptr   <= '0;
			mark_ptr <= '0;
		end
		else
		begin
			if (buf_pop)
				wr_ptr <= wr_ptr + 1'b1;
			rd_ptr <= next_rd_ptr;
			if (!ctrl_hold)
				mark_ptr <= next_rd_ptr;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			port_a_bus_out <= '0;
			port_a_bus_oe  <= 1'b0;
			port_b_bus_out <= '0;
			port_b_bus_oe  <= 1'b0;
		end
		else
		begin
			port_a_bus_oe <= ~port_a_select_n & ~port_a_write;
			port_b_bus_oe <= ~port_b_select_n & ~port_b_write;
			if (a_mb_rd)
				port_a_bus_out <= mail_ba;
			if (b_mb_rd)
				port_b_bus_out <= mail_ab;
			else if (b_fifo_rd)
				port_b_bus_out <= mem[rd_ptr[dcf_pkg::ADDR_W-1:0]];
		end
	end

	// new mail wins over a collection in the same cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mail_ab           <= '0;
			mail_ba           <= '0;
			inbox_to_b_flag_n <= 1'b1;
			inbox_to_a_flag_n <= 1'b1;
		end
		else
		begin
			if (a_mb_wr)
				mail_ab <= port_a_bus_in;
			if (b_mb_wr)
				mail_ba <= port_b_bus_in;
			if (b_mb_rd)
				inbox_to_b_flag_n <= 1'b1;
			if (a_mb_wr)
				inbox_to_b_flag_n <= 1'b0;
			if (a_mb_rd)
				inbox_to_a_flag_n <= 1'b1;
			if (b_mb_wr)
				inbox_to_a_flag_n <= 1'b0;
		end
	end

	// ir reserves slack for the writes that can land before it is seen low
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ir_s1              <= 1'b0;
			input_ready_flag   <= 1'b0;
			af_s1              <= 1'b1;
			almost_full_flag_n <= 1'b1;
		end
		else if (a_edge)
		begin
			ir_s1              <= (prog == dcf_pkg::DCF_PROG_DONE) && (occ <= dcf_pkg::IR_LIMIT);
			input_ready_flag   <= ir_s1;
			af_s1              <= (dcf_pkg::DEPTH_CNT - held) > dcf_pkg::PTR_W'(ofs_y);
			almost_full_flag_n <= af_s1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			or_s1               <= 1'b0;
			output_ready_flag   <= 1'b0;
			ae_s1               <= 1'b0;
			almost_empty_flag_n <= 1'b0;
		end
		else if (b_edge)
		begin
			or_s1               <= ~arr_empty;
			output_ready_flag   <= or_s1;
			ae_s1               <= stored > dcf_pkg::PTR_W'(ofs_x);
			almost_empty_flag_n <= ae_s1;
		end
	end

	// offsets: parallel takes the first two port a fifo writes, y then x
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			prog    <= dcf_pkg::DCF_PROG_WAIT;
			ofs_x   <= dcf_pkg::OFS_RESET;
			ofs_y   <= dcf_pkg::OFS_RESET;
			ser_cnt <= '0;
		end
		else
		begin
			unique case (prog)
				dcf_pkg::DCF_PROG_WAIT:
					if (ctrl_serial)
					begin
						if (a_edge && !offset_serial_strobe_n)
						begin
							{ofs_y, ofs_x} <= {ofs_y[dcf_pkg::OFS_W-2:0], ofs_x, offset_serial_bit};
							ser_cnt        <= ser_cnt + 1'b1;
							if (ser_cnt == dcf_pkg::SER_LAST)
								prog <= dcf_pkg::DCF_PROG_DONE;
						end
					end
					else if (a_fifo_wr)
					begin
						ofs_y <= port_a_bus_in[dcf_pkg::OFS_W-1:0];
						prog  <= dcf_pkg::DCF_PROG_PAR_X;
					end
				dcf_pkg::DCF_PROG_PAR_X:
					if (a_fifo_wr)
					begin
						ofs_x <= port_a_bus_in[dcf_pkg::OFS_W-1:0];
						prog  <= dcf_pkg::DCF_PROG_DONE;
					end
				dcf_pkg::DCF_PROG_DONE:
					prog <= dcf_pkg::DCF_PROG_DONE;
			endcase
		end
	end

	always_comb
	begin
		rd_word = '0;
		rd_hit  = 1'b1;
		unique case (s_axi_araddr)
			dcf_pkg::REG_CTRL:
			begin
				rd_word[dcf_pkg::CTRL_SERIAL] = ctrl_serial;
				rd_word[dcf_pkg::CTRL_HOLD]   = ctrl_hold;
			end
			dcf_pkg::REG_STATUS:
			begin
				rd_word[dcf_pkg::ST_IR]      = input_ready_flag;
				rd_word[dcf_pkg::ST_OR]      = output_ready_flag;
				rd_word[dcf_pkg::ST_AF_N]    = almost_full_flag_n;
				rd_word[dcf_pkg::ST_AE_N]    = almost_empty_flag_n;
				rd_word[dcf_pkg::ST_MB_AB_N] = inbox_to_b_flag_n;
				rd_word[dcf_pkg::ST_MB_BA_N] = inbox_to_a_flag_n;
				rd_word[dcf_pkg::ST_PROG]    = prog == dcf_pkg::DCF_PROG_DONE;
				rd_word[dcf_pkg::ST_CNT_LSB +: dcf_pkg::PTR_W] = stored;
			end
			dcf_pkg::REG_OFFSETS:
			begin
				rd_word[dcf_pkg::OFS_W-1:0]                    = ofs_x;
				rd_word[dcf_pkg::OFS_Y_LSB +: dcf_pkg::OFS_W] = ofs_y;
			end
			default: rd_hit = 1'b0;
		endcase
		do_write = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= dcf_pkg::RESP_OKAY;
			aw_q          <= '0;
			w_q           <= '0;
			wstrb0_q      <= 1'b0;
			ctrl_serial   <= 1'b0;
			ctrl_hold     <= 1'b0;
			retx          <= 1'b0;
		end
		else
		begin
			retx <= 1'b0;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_q          <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_q          <= s_axi_wdata;
				wstrb0_q     <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			if (do_write)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= dcf_pkg::RESP_OKAY;
				if (aw_q == dcf_pkg::REG_CTRL)
				begin
					if (wstrb0_q)
					begin
						ctrl_serial <= w_q[dcf_pkg::CTRL_SERIAL];
						ctrl_hold   <= w_q[dcf_pkg::CTRL_HOLD];
						retx        <= w_q[dcf_pkg::CTRL_RETX];
					end
				end
				else if (aw_q != dcf_pkg::REG_STATUS && aw_q != dcf_pkg::REG_OFFSETS)
					s_axi_bresp <= dcf_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= dcf_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_hit ? dcf_pkg::RESP_OKAY : dcf_pkg::RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_mail_in;
		a_mb_wr;
	endsequence
	sequence s_mail_out;
		b_mb_rd && !a_mb_wr;
	endsequence
	sequence s_ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_r_wait;
		s_axi_rvalid && !s_axi_rready;
	endsequence

	a_ir_after_reset: assert property ($rose(aresetn) |-> !input_ready_flag)
		else $error("input ready high right after reset");
	a_ir_on_edge: assert property (!$stable(input_ready_flag) |-> $past(a_edge))
		else $error("input ready moved off a port a edge");
	a_or_on_edge: assert property (!$stable(almost_empty_flag_n) || !$stable(output_ready_flag) |-> $past(b_edge))
		else $error("port b flag moved off a port b edge");
	a_ae_two_stage: assert property (b_edge |=> almost_empty_flag_n == $past(ae_s1))
		else $error("almost empty skipped its stage");
	a_mail_set: assert property (s_mail_in |=> !inbox_to_b_flag_n)
		else $error("mail flag not low after port a write");
	a_mail_clear: assert property (s_mail_out |=> inbox_to_b_flag_n)
		else $error("mail flag not high after port b read");
	a_array_bound: assert property (held <= dcf_pkg::DEPTH_CNT)
		else $error("array overfilled");
	a_read_gate: assert property (b_op && !output_ready_flag && !retx |=> rd_ptr == $past(rd_ptr))
		else $error("read pointer moved while not ready");
	a_ir_blocks: assert property (a_fifo_wr && !input_ready_flag |=> buf_cnt <= $past(buf_cnt))
		else $error("write taken while input ready low");
	a_axi_read: assert property (s_ar_taken |=> s_axi_rvalid ##0 s_r_wait[*1] |=> $stable(s_axi_rdata))
		else $error("read answer late or unstable");
endmodule

/* File: dcf_fifo_mailbox_tb.sv */
// self-checking bench: offsets, fill, drain, retransmit, mailboxes, register bus
`timescale 1ns/10ps
`define CHK(nm, e, g) \
	begin \
		num_checks++; \
		if ((g) !== (e)) \
		begin \
			err_total++; \
			$display("unexpected %s: expected %h, seen %h", nm, e, g); \
		end \
	end
module dcf_fifo_mailbox_tb;
	logic                        aclk, aresetn, offset_serial_strobe_n, offset_serial_bit, b_done;
	logic                        port_a_clock, port_a_select_n, port_a_gate, port_a_write, port_a_mbox, port_a_bus_oe;
	logic                        port_b_clock, port_b_select_n, port_b_gate, port_b_write, port_b_mbox, port_b_bus_oe;
	logic [dcf_pkg::DATA_W-1:0]  port_a_bus_in, port_a_bus_out, port_b_bus_in, port_b_bus_out, a_q, b_q, d, want;
	logic                        input_ready_flag, output_ready_flag, almost_full_flag_n, almost_empty_flag_n;
	logic                        inbox_to_b_flag_n, inbox_to_a_flag_n;
	logic [3:0]                  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0]                 s_axi_wdata, s_axi_rdata, rd, rng;
	logic [1:0]                  s_axi_bresp, s_axi_rresp, rs;
	logic                        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic                        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [21:0]                 ofs = {11'h004, 11'h003};
	logic [35:0]                 exp_q[$];
	logic [35:0]                 rt[3];
	int                          err_total = 0;
	int                          num_checks = 0;
	int                          cycles = 0;
	int                          n;

	dcf_fifo_mailbox DUT (.*);
	dcf_port_model #(.HB(2)) pa (.aclk(aclk), .pclk(port_a_clock), .sel_n(port_a_select_n), .gate(port_a_gate),
		.wr(port_a_write), .mb(port_a_mbox), .bus_in(port_a_bus_in), .bus_out(port_a_bus_out),
		.bus_oe(port_a_bus_oe), .q(a_q), .done());
	// port b runs at half the port a rate; both count aclk from zero, so their phase is fixed
	dcf_port_model #(.HB(3)) pb (.aclk(aclk), .pclk(port_b_clock), .sel_n(port_b_select_n), .gate(port_b_gate),
		.wr(port_b_write), .mb(port_b_mbox), .bus_in(port_b_bus_in), .bus_out(port_b_bus_out),
		.bus_oe(port_b_bus_oe), .q(b_q), .done(b_done));

	always #12.5 aclk = ~aclk;

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	task automatic report_and_stop();
		if (err_total == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// fill plus drain needs about 49k cycles
	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 90000)
		begin
			`CHK("cycle limit", 1'b0, 1'b1)
			report_and_stop();
		end
	end

	always @(posedge aclk)
		if (b_done === 1'b1)
		begin
			want = exp_q.size() > 0 ? exp_q.pop_front() : ~b_q;
			`CHK("port b word", want, b_q)
		end

	// a bus is driven one cycle after a read select is seen, and released one cycle after it goes
	logic a_oe_exp = 1'b0;
	logic b_oe_exp = 1'b0;
	always @(posedge aclk)
	begin
		if (aresetn === 1'b1)
		begin
			`CHK("port a drive", a_oe_exp, port_a_bus_oe)
			`CHK("port b drive", b_oe_exp, port_b_bus_oe)
		end
		a_oe_exp <= ~port_a_select_n & ~port_a_write;
		b_oe_exp <= ~port_b_select_n & ~port_b_write;
	end

	task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] r);
		logic ap, wp;
		@(posedge aclk);
		ap = 1'b1;
		wp = 1'b1;
		s_axi_awaddr  <= a;
		s_axi_wdata   <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		while (ap || wp)
		begin
			@(posedge aclk);
			ap = ap & ~s_axi_awready;
			wp = wp & ~s_axi_wready;
			s_axi_awvalid <= ap;
			s_axi_wvalid  <= wp;
		end
		while (s_axi_bvalid !== 1'b1)
			@(posedge aclk);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic reg_is(input logic [3:0] a, input logic [31:0] v, input logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		@(posedge aclk);
		while (s_axi_arready !== 1'b1)
			@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1)
			@(posedge aclk);
		s_axi_rready <= 1'b0;
		`CHK("register read data", v, s_axi_rdata)
		`CHK("register read response", r, s_axi_rresp)
	endtask

	task automatic ser_bit(input logic b);
		pa.sync();
		offset_serial_strobe_n <= 1'b0;
		offset_serial_bit      <= b;
		repeat (2) @(posedge aclk);
		offset_serial_strobe_n <= 1'b1;
		offset_serial_bit      <= ~b;
	endtask

	initial
	begin
		aclk = 1'b0;
		aresetn = 1'b0;
		offset_serial_strobe_n = 1'b1;
		offset_serial_bit = 1'b0;
		rng = 32'h36;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		reg_is(dcf_pkg::REG_STATUS, 32'h34, dcf_pkg::RESP_OKAY);
		reg_is(4'hc, 32'h0, dcf_pkg::RESP_SLVERR);
		axi_wr(4'hc, 32'h1, rs);
		`CHK("unmapped write response", dcf_pkg::RESP_SLVERR, rs)
		axi_wr(dcf_pkg::REG_CTRL, 32'h1, rs);
		for (int i = 21; i >= 0; i--)
			ser_bit(ofs[i]);
		reg_is(dcf_pkg::REG_OFFSETS, {5'h0, ofs[21:11], 5'h0, ofs[10:0]}, dcf_pkg::RESP_OKAY);
		pa.op(1'b1, 1'b0, 1'b0, 36'h1);
		repeat (3) pb.sync();
		reg_is(dcf_pkg::REG_STATUS, 32'h75, dcf_pkg::RESP_OKAY);
		n = 0;
		while (input_ready_flag === 1'b1 && n < 2100)
		begin
			rng = xs(rng);
			d = {rng[3:0], xs(rng)};
			pa.op(1'b1, 1'b0, 1'b1, d);
			exp_q.push_back(d);
			n++;
		end
		pa.op(1'b1, 1'b0, 1'b1, 36'h0);
		repeat (3) pa.sync();
		`CHK("almost full", 1'b0, almost_full_flag_n)
		`CHK("input ready", 1'b0, input_ready_flag)
		// the two words parked in the buffer are not part of the array count
		axi_rd_count: reg_is(dcf_pkg::REG_STATUS, {4'h0, dcf_pkg::DEPTH_CNT, 16'h007a}, dcf_pkg::RESP_OKAY);
		`CHK("output ready", 1'b1, output_ready_flag)
		`CHK("almost empty", 1'b1, almost_empty_flag_n)
		d = exp_q[$];
		n = exp_q.size();
		repeat (n) pb.op(1'b0, 1'b0, 1'b1, 36'h0);
		repeat (3) pb.sync();
		`CHK("output ready", 1'b0, output_ready_flag)
		`CHK("almost empty", 1'b0, almost_empty_flag_n)
		exp_q.push_back(d);
		pb.op(1'b0, 1'b0, 1'b1, 36'h0);
		axi_wr(dcf_pkg::REG_CTRL, 32'h4, rs);
		for (int i = 0; i < 3; i++)
		begin
			rng = xs(rng);
			rt[i] = {rng[7:4], xs(rng)};
			pa.op(1'b1, 1'b0, 1'b1, rt[i]);
			exp_q.push_back(rt[i]);
		end
		repeat (3) pb.sync();
		repeat (3) pb.op(1'b0, 1'b0, 1'b1, 36'h0);
		axi_wr(dcf_pkg::REG_CTRL, 32'h6, rs);
		foreach (rt[i])
			exp_q.push_back(rt[i]);
		repeat (3) pb.sync();
		repeat (3) pb.op(1'b0, 1'b0, 1'b1, 36'h0);
		axi_wr(dcf_pkg::REG_CTRL, 32'h0, rs);
		pa.op(1'b1, 1'b1, 1'b1, rt[0]);
		`CHK("a to b mail flag", 1'b0, inbox_to_b_flag_n)
		pb.op(1'b0, 1'b1, 1'b1, 36'h0);
		`CHK("a to b mail", rt[0], b_q)
		`CHK("a to b mail flag", 1'b1, inbox_to_b_flag_n)
		pb.op(1'b1, 1'b1, 1'b1, rt[1]);
		`CHK("b to a mail flag", 1'b0, inbox_to_a_flag_n)
		pa.op(1'b0, 1'b1, 1'b1, 36'h0);
		`CHK("b to a mail", rt[1], a_q)
		`CHK("b to a mail flag", 1'b1, inbox_to_a_flag_n)
		`CHK("words left over", 0, exp_q.size())
		// a second reset drops serial mode, so the offsets now come in parallel, y first
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		pa.op(1'b1, 1'b0, 1'b1, 36'h5);
		pa.op(1'b1, 1'b0, 1'b1, 36'h6);
		reg_is(dcf_pkg::REG_OFFSETS, 32'h0005_0006, dcf_pkg::RESP_OKAY);
		report_and_stop();
	end
endmodule

/* File: dcf_pkg.sv */
// constants and types shared by the dual-clock fifo with mailboxes
package dcf_pkg;
	localparam int             DATA_W      = 36;
	localparam int             DEPTH       = 2048;
	localparam int             ADDR_W      = 11;
	localparam int             PTR_W       = 12;
	localparam int             OFS_W       = 11;
	localparam int             BUF_DEPTH   = 2;
	localparam int             IR_SLACK    = 3;
	localparam int             AXI_AW      = 4;
	localparam int             AXI_DW      = 32;
	localparam logic [11:0]    DEPTH_CNT   = 12'h800;
	localparam logic [11:0]    IR_LIMIT    = DEPTH_CNT + 12'(BUF_DEPTH) - 12'(IR_SLACK);
	localparam logic [1:0]     BUF_FULL    = 2'h2;
	localparam logic [4:0]     SER_LAST    = 5'h15;
	localparam logic [10:0]    OFS_RESET   = 11'h000;
	localparam logic [3:0]     REG_CTRL    = 4'h0;
	localparam logic [3:0]     REG_STATUS  = 4'h4;
	localparam logic [3:0]     REG_OFFSETS = 4'h8;
	localparam int             CTRL_SERIAL = 0;
	localparam int             CTRL_RETX   = 1;
	localparam int             CTRL_HOLD   = 2;
	localparam int             ST_IR       = 0;
	localparam int             ST_OR       = 1;
	localparam int             ST_AF_N     = 2;
	localparam int             ST_AE_N     = 3;
	localparam int             ST_MB_AB_N  = 4;
	localparam int             ST_MB_BA_N  = 5;
	localparam int             ST_PROG     = 6;
	localparam int             ST_CNT_LSB  = 16;
	localparam int             OFS_Y_LSB   = 16;
	localparam logic [1:0]     RESP_OKAY   = 2'h0;
	localparam logic [1:0]     RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {DCF_PROG_WAIT, DCF_PROG_PAR_X, DCF_PROG_DONE} dcf_prog_t;
endpackage

/* File: dcf_port_model.sv */
// port master model: free-running port clock, one qualified edge per call
`timescale 1ns/10ps
module dcf_port_model #(
	parameter int HB = 2
) (
	input  wire logic          aclk,
	output logic               pclk,
	output logic               sel_n,
	output logic               gate,
	output logic               wr,
	output logic               mb,
	output logic [35:0]        bus_in,
	input  wire logic [35:0]   bus_out,
	input  wire logic          bus_oe,
	output logic [35:0]        q,
	output logic               done
);
	logic [HB:0] ph = '0;
	logic [35:0] drv = '0;
	initial
	begin
		pclk = 1'b0;
		sel_n = 1'b1;
		gate = 1'b0;
		wr = 1'b0;
		mb = 1'b0;
		q = '0;
		done = 1'b0;
	end
	// the port clock never stops, even between operations
	always @(posedge aclk)
	begin
		ph   <= ph + 1'b1;
		pclk <= ph[HB];
	end
	// released bus shows the inverse of our last word, never a stale copy
	assign bus_in = bus_oe ? bus_out : drv;
	task automatic sync();
		@(posedge aclk);
		while (ph != {1'b0, {HB{1'b1}}})
			@(posedge aclk);
	endtask
	task automatic op(input logic w, input logic m, input logic g, input logic [35:0] d);
		sync();
		sel_n <= 1'b0;
		gate  <= g;
		wr    <= w;
		mb    <= m;
		drv   <= d;
		repeat (2) @(posedge aclk);
		sel_n <= 1'b1;
		gate  <= 1'b0;
		drv   <= ~d;
		repeat (2) @(posedge aclk);
		q    <= bus_out;
		done <= ~w & ~m & g;
		@(posedge aclk);
		done <= 1'b0;
	endtask
endmodule
